// ### shared/twu_defs.svh
// Purpose: offsets, fields, reset values and codes of the waveform unit
// Assumes: 32-bit AXI4-Lite word per register, 8-bit address
// Notes: definitions only
`ifndef TWU_DEFS_SVH
`define TWU_DEFS_SVH
// ----------------------------------------------------------------
// register byte offsets
// ----------------------------------------------------------------
`define TWU_OFF_CTRL 8'h00
`define TWU_OFF_COUNT 8'h04
`define TWU_OFF_CMP_A 8'h08
`define TWU_OFF_CMP_B 8'h0C
`define TWU_OFF_STATUS 8'h10
`define TWU_OFF_OUTST 8'h14
`define TWU_OFF_FORCE 8'h18
// ----------------------------------------------------------------
// fields
// ----------------------------------------------------------------
`define TWU_WGM_LSB 0
`define TWU_COMA_LSB 4
`define TWU_COMB_LSB 6
`define TWU_ST_OVF 0
`define TWU_ST_MA 1
`define TWU_ST_MB 2
// ----------------------------------------------------------------
// reset values and codes
// ----------------------------------------------------------------
`define TWU_RST_CTRL 8'h00
`define TWU_RST_BYTE 8'h00
`define TWU_WGM_NORMAL 3'h0
`define TWU_WGM_CLR 3'h2
`define TWU_WGM_FPWM_MAX 3'h3
`define TWU_WGM_FPWM_CMP 3'h7
`define TWU_MAX 8'hFF
`define TWU_BOTTOM 8'h00
`define TWU_RESP_OKAY 2'h0
`define TWU_RESP_SLVERR 2'h2
`endif

// ### shared/twu_pkg.sv
// Purpose: types of the waveform unit
// Assumes: nothing
// Notes: compare output mode encoding is fixed by the hardware
package twu_pkg;
  typedef logic [7:0] twu_byte_t;
  typedef enum logic [1:0] {
    COM_OFF = 2'h0,
    COM_TOGGLE = 2'h1,
    COM_CLEAR = 2'h2,
    COM_SET = 2'h3
  } twu_com_t;
endpackage

// ### verilog/twu_top.sv
// Purpose: timer counter with waveform generation and compare outputs
// Assumes: timer_tick is a one-cycle enable from an outside prescaler
// Notes: registers over AXI4-Lite, two compare channels A and B
//
// The AXI4-Lite interface to the registers and the address map were left to the implementer.
`timescale 1ns/1ps
`include "twu_defs.svh"
module twu_top
  import twu_pkg::*;
#(
  parameter int ADDR_W = 8,
  parameter int NCH = 2
) (
  // clock and reset
  input wire logic aclk,
  input wire logic aresetn,
  // timer clock enable
  input wire logic timer_tick,
  // port pins
  input wire logic [NCH-1:0] port_out_value,
  input wire logic [NCH-1:0] pin_direction_bit,
  output logic [NCH-1:0] pin_out,
  output logic [NCH-1:0] pin_oe,
  // axi write address
  input wire logic [ADDR_W-1:0] s_axi_awaddr,
  input wire logic s_axi_awvalid,
  output logic s_axi_awready,
  // axi write data
  input wire logic [31:0] s_axi_wdata,
  input wire logic [3:0] s_axi_wstrb,
  input wire logic s_axi_wvalid,
  output logic s_axi_wready,
  // axi write response
  output logic [1:0] s_axi_bresp,
  output logic s_axi_bvalid,
  input wire logic s_axi_bready,
  // axi read address
  input wire logic [ADDR_W-1:0] s_axi_araddr,
  input wire logic s_axi_arvalid,
  output logic s_axi_arready,
  // axi read data
  output logic [31:0] s_axi_rdata,
  output logic [1:0] s_axi_rresp,
  output logic s_axi_rvalid,
  input wire logic s_axi_rready
);

  // ----------------------------------------------------------------
  // state
  // ----------------------------------------------------------------
  twu_byte_t ctrl;
  twu_byte_t counter_value;
  twu_byte_t [NCH-1:0] cmp_buf;
  twu_byte_t [NCH-1:0] channel_compare_value;
  logic [NCH-1:0] compare_output_state;
  logic overflow_flag;
  logic [NCH-1:0] match_flag;
  logic match_block;
  logic [ADDR_W-1:0] wr_addr;
  logic [7:0] wr_byte;
  logic wr_lane;
  function automatic logic hit(input logic [ADDR_W-1:0] a,
                               input logic [7:0] off);
    hit = (a[ADDR_W-1:2] == off[ADDR_W-1:2]);
  endfunction
  function automatic logic match_act(input logic o, input twu_com_t c);
    case (c)
      COM_TOGGLE: match_act = ~o;
      COM_CLEAR: match_act = 1'b0;
      COM_SET: match_act = 1'b1;
      default: match_act = o;
    endcase
  endfunction

  // ----------------------------------------------------------------
  // decode
  // ----------------------------------------------------------------
  logic [2:0] waveform_mode_field;
  twu_com_t [NCH-1:0] compare_output_mode;
  logic is_pwm, clear_on_match_mode, at_top;
  twu_byte_t top_value;
  logic [NCH-1:0] match;
  logic wr_en, wr_ctrl, wr_count, wr_status, wr_outst, wr_force;
  logic [NCH-1:0] wr_cmp;
  assign waveform_mode_field = ctrl[`TWU_WGM_LSB +: 3];
  assign compare_output_mode[0] = twu_com_t'(ctrl[`TWU_COMA_LSB +: 2]);
  assign compare_output_mode[1] = twu_com_t'(ctrl[`TWU_COMB_LSB +: 2]);
  // only the waveform mode field enters the counting logic
  assign is_pwm = (waveform_mode_field == `TWU_WGM_FPWM_MAX) ||
                  (waveform_mode_field == `TWU_WGM_FPWM_CMP);
  assign clear_on_match_mode = (waveform_mode_field == `TWU_WGM_CLR);
  // top compares the active register, never the buffer
  assign top_value = (waveform_mode_field == `TWU_WGM_FPWM_MAX) ?
                     `TWU_MAX : channel_compare_value[0];
  assign at_top = timer_tick && is_pwm && (counter_value == top_value);
  // a counter write blocks matches through the next tick
  generate
    for (genvar ch = 0; ch < NCH; ch++) begin : g_cmp
      assign match[ch] = timer_tick && !match_block &&
                         (counter_value == channel_compare_value[ch]);
      assign wr_cmp[ch] = wr_en && wr_lane &&
                          hit(wr_addr, `TWU_OFF_CMP_A + 8'(4 * ch));
    end
  endgenerate
  assign wr_en = !s_axi_awready && !s_axi_wready && !s_axi_bvalid;
  assign wr_ctrl = wr_en && wr_lane && hit(wr_addr, `TWU_OFF_CTRL);
  assign wr_count = wr_en && wr_lane && hit(wr_addr, `TWU_OFF_COUNT);
  assign wr_status = wr_en && wr_lane && hit(wr_addr, `TWU_OFF_STATUS);
  assign wr_outst = wr_en && wr_lane && hit(wr_addr, `TWU_OFF_OUTST);
  assign wr_force = wr_en && wr_lane && hit(wr_addr, `TWU_OFF_FORCE);

  // ----------------------------------------------------------------
  // axi write channel
  // ----------------------------------------------------------------
  // address and data are held until both are in, then one write cycle
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      s_axi_awready <= 1'b1;
      s_axi_wready <= 1'b1;
      s_axi_bvalid <= 1'b0;
      s_axi_bresp <= `TWU_RESP_OKAY;
      wr_addr <= '0;
      wr_byte <= `TWU_RST_BYTE;
      wr_lane <= 1'b0;
    end else begin
      if (s_axi_awvalid && s_axi_awready) begin
        s_axi_awready <= 1'b0;
        wr_addr <= s_axi_awaddr;
      end
      if (s_axi_wvalid && s_axi_wready) begin
        s_axi_wready <= 1'b0;
        wr_byte <= s_axi_wdata[7:0];
        wr_lane <= s_axi_wstrb[0];
      end
      if (wr_en) begin
        s_axi_bvalid <= 1'b1;
        s_axi_bresp <= (wr_addr[ADDR_W-1:2] >
                        `TWU_OFF_FORCE >> 2) ?
                       `TWU_RESP_SLVERR : `TWU_RESP_OKAY;
      end
      if (s_axi_bvalid && s_axi_bready) begin
        s_axi_bvalid <= 1'b0;
        s_axi_awready <= 1'b1;
        s_axi_wready <= 1'b1;
      end
    end
  end

  // ----------------------------------------------------------------
  // axi read channel
  // ----------------------------------------------------------------
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      s_axi_arready <= 1'b1;
      s_axi_rvalid <= 1'b0;
      s_axi_rdata <= 32'h00000000;
      s_axi_rresp <= `TWU_RESP_OKAY;
    end else begin
      if (s_axi_arvalid && s_axi_arready) begin
        s_axi_arready <= 1'b0;
        s_axi_rvalid <= 1'b1;
        s_axi_rresp <= `TWU_RESP_OKAY;
        s_axi_rdata <= 32'h00000000;
        if (hit(s_axi_araddr, `TWU_OFF_CTRL))
          s_axi_rdata[7:0] <= ctrl;
        else if (hit(s_axi_araddr, `TWU_OFF_COUNT))
          s_axi_rdata[7:0] <= counter_value;
        else if (hit(s_axi_araddr, `TWU_OFF_CMP_A))
          s_axi_rdata[7:0] <= cmp_buf[0];
        else if (hit(s_axi_araddr, `TWU_OFF_CMP_B))
          s_axi_rdata[7:0] <= cmp_buf[1];
        else if (hit(s_axi_araddr, `TWU_OFF_STATUS))
          s_axi_rdata[2:0] <= {match_flag, overflow_flag};
        else if (hit(s_axi_araddr, `TWU_OFF_OUTST))
          s_axi_rdata[NCH-1:0] <= compare_output_state;
        else if (!hit(s_axi_araddr, `TWU_OFF_FORCE))
          s_axi_rresp <= `TWU_RESP_SLVERR;
      end
      if (s_axi_rvalid && s_axi_rready) begin
        s_axi_rvalid <= 1'b0;
        s_axi_arready <= 1'b1;
      end
    end
  end

  // ----------------------------------------------------------------
  // control register
  // ----------------------------------------------------------------
  // compare mode changes act at once, hence at the next match
  always_ff @(posedge aclk) begin
    if (!aresetn)
      ctrl <= `TWU_RST_CTRL;
    else if (wr_ctrl)
      ctrl <= wr_byte;
  end

  // ----------------------------------------------------------------
  // counter
  // ----------------------------------------------------------------
  // a software write beats any clear or count in the same cycle
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      counter_value <= `TWU_BOTTOM;
    end else if (wr_count) begin
      counter_value <= wr_byte;
    end else if (timer_tick) begin
      if (at_top)
        counter_value <= `TWU_BOTTOM;
      else if (clear_on_match_mode &&
               counter_value == channel_compare_value[0])
        counter_value <= `TWU_BOTTOM;
      else
        counter_value <= 8'(counter_value + 8'h01);
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn)
      match_block <= 1'b0;
    else if (wr_count)
      match_block <= 1'b1;
    else if (timer_tick)
      match_block <= 1'b0;
  end

  // ----------------------------------------------------------------
  // compare registers
  // ----------------------------------------------------------------
  // the active value reloads from the buffer at top so a pwm period never sees two values
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      cmp_buf <= '0;
      channel_compare_value <= '0;
    end else begin
      for (int ch = 0; ch < NCH; ch++) begin
        if (wr_cmp[ch]) begin
          cmp_buf[ch] <= wr_byte;
          if (!is_pwm)
            channel_compare_value[ch] <= wr_byte;
        end
        if (at_top)
          channel_compare_value[ch] <= cmp_buf[ch];
      end
    end
  end

  // ----------------------------------------------------------------
  // flags
  // ----------------------------------------------------------------
  // write one to clear; a set in the same cycle wins
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      overflow_flag <= 1'b0;
      match_flag <= '0;
    end else begin
      if (wr_status && wr_byte[`TWU_ST_OVF])
        overflow_flag <= 1'b0;
      if (timer_tick && (is_pwm ? counter_value == top_value :
                         counter_value == `TWU_MAX))
        overflow_flag <= 1'b1;
      for (int ch = 0; ch < NCH; ch++) begin
        if (wr_status && wr_byte[`TWU_ST_MA + ch])
          match_flag[ch] <= 1'b0;
        if (match[ch])
          match_flag[ch] <= 1'b1;
      end
    end
  end

  // ----------------------------------------------------------------
  // compare output state
  // ----------------------------------------------------------------
  // bottom beats match in pwm, so compare at max holds a steady level
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      compare_output_state <= '0;
    end else begin
      for (int ch = 0; ch < NCH; ch++) begin
        if (wr_outst)
          compare_output_state[ch] <= wr_byte[ch];
        else if (wr_force && wr_byte[ch] && !is_pwm)
          compare_output_state[ch] <= match_act(
            compare_output_state[ch], compare_output_mode[ch]);
        else if (at_top && compare_output_mode[ch] == COM_CLEAR)
          compare_output_state[ch] <= 1'b1;
        else if (at_top && compare_output_mode[ch] == COM_SET)
          compare_output_state[ch] <= 1'b0;
        else if (match[ch])
          compare_output_state[ch] <= match_act(
            compare_output_state[ch],
            compare_output_mode[ch]);
      end
    end
  end

  // ----------------------------------------------------------------
  // pin drive
  // ----------------------------------------------------------------
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      pin_out <= '0;
      pin_oe <= '0;
    end else begin
      for (int ch = 0; ch < NCH; ch++) begin
        pin_out[ch] <= (compare_output_mode[ch] != COM_OFF) ?
                       compare_output_state[ch] :
                       port_out_value[ch];
        pin_oe[ch] <= pin_direction_bit[ch];
      end
    end
  end

  // ----------------------------------------------------------------
  // checks
  // ----------------------------------------------------------------
  default clocking cb @(posedge aclk); endclocking
  default disable iff (!aresetn);
  a_pin_override: assert property (
    compare_output_mode[0] != COM_OFF |=>
      pin_out[0] == $past(compare_output_state[0]))
    else $error("pin a not driven by output state");
  a_pin_direction: assert property (
    ##1 pin_oe == $past(pin_direction_bit))
    else $error("pin enable does not follow direction");
  a_mode_zero_hold: assert property (
    match[0] && compare_output_mode[0] == COM_OFF && !wr_outst &&
    !wr_force |=> $stable(compare_output_state[0]))
    else $error("output changed with compare mode zero");
  a_normal_wrap: assert property (
    timer_tick && waveform_mode_field == `TWU_WGM_NORMAL &&
    counter_value == `TWU_MAX && !wr_count |=>
      counter_value == `TWU_BOTTOM && overflow_flag)
    else $error("normal mode wrap or overflow wrong");
  a_normal_count: assert property (
    timer_tick && waveform_mode_field == `TWU_WGM_NORMAL &&
    !wr_count |=> counter_value == 8'($past(counter_value) + 8'h01))
    else $error("normal mode did not increment");
  a_match_clear: assert property (
    timer_tick && clear_on_match_mode && !wr_count &&
    counter_value == channel_compare_value[0] |=> counter_value == '0)
    else $error("clear on match did not clear");
  a_match_toggle: assert property (
    match[0] && clear_on_match_mode && compare_output_mode[0] == COM_TOGGLE &&
    !wr_outst && !wr_force |=>
      compare_output_state[0] != $past(compare_output_state[0]))
    else $error("clear on match toggle missing");
  a_pwm_bottom: assert property (
    at_top && compare_output_mode[0] == COM_CLEAR && !wr_outst &&
    !wr_count |=> compare_output_state[0] &&
      counter_value == `TWU_BOTTOM)
    else $error("fast pwm bottom set missing");
  a_pwm_buffered: assert property (
    wr_cmp[0] && is_pwm && !at_top |=> $stable(channel_compare_value[0]))
    else $error("pwm compare write bypassed buffer");
  a_match_flag: assert property (
    match[1] |=> match_flag[1])
    else $error("match flag not set");
  a_force_noflag: assert property (
    wr_force && !match[0] && !wr_status && !match_flag[0] |=>
      !match_flag[0])
    else $error("force set the match flag");
  a_bresp_hold: assert property (
    s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid ##0 $stable(s_axi_bresp))
    else $error("write response dropped");
  c_match_toggle: cover property (
    match[0] && clear_on_match_mode && compare_output_mode[0] == COM_TOGGLE);
  c_pwm_spike: cover property (
    at_top && channel_compare_value[0] == `TWU_BOTTOM ##[1:4] match[0]);
  c_force: cover property (wr_force && !is_pwm);
  c_ovf_clear_race: cover property (
    wr_status && timer_tick && counter_value == `TWU_MAX);

endmodule

// ### test/twu_pin_load.sv
// Purpose: load on the compare output pins
// Assumes: one pin per channel, no pull resistor
// Notes: a released pin shows the inverse of its last driven level
`timescale 1ns/1ps
module twu_pin_load #(
  parameter int NCH = 2
) (
  // clock
  input wire logic aclk,
  // pin side
  input wire logic [NCH-1:0] pin_out,
  input wire logic [NCH-1:0] pin_oe,
  output logic [NCH-1:0] pin_level
);
  logic [NCH-1:0] last;

  // a floating pin must never pass for a stable copy of the old level
  always_ff @(posedge aclk) begin
    for (int i = 0; i < NCH; i++) begin
      if (pin_oe[i]) begin
        last[i] <= pin_out[i];
      end
    end
  end

  always_comb begin
    for (int i = 0; i < NCH; i++) begin
      pin_level[i] = pin_oe[i] ? pin_out[i] : ~last[i];
    end
  end
endmodule

// ### test/test_timer_waveform_output_unit.sv
// Purpose: self-checking bench of the waveform unit
// Assumes: timer_tick pulsed by the bench, one edge per tick
// Notes: registers reached over AXI4-Lite tasks
`timescale 1ns/1ps
`include "twu_defs.svh"
module test_timer_waveform_output_unit
  import twu_pkg::*;
;
  // ----------------------------------------------------------------
  // signals
  // ----------------------------------------------------------------
  localparam int LIMIT = 20000;
  logic aclk = 1'h0;
  logic aresetn = 1'h0;
  logic timer_tick = 1'h0;
  logic [1:0] port_out_value = 2'h0;
  logic [1:0] pin_direction_bit = 2'h0;
  logic [1:0] pin_out, pin_oe, pin_level;
  logic [7:0] s_axi_awaddr = 8'h00;
  logic [7:0] s_axi_araddr = 8'h00;
  logic [31:0] s_axi_wdata = 32'h0;
  logic [3:0] s_axi_wstrb = 4'hF;
  logic s_axi_awvalid = 1'h0, s_axi_wvalid = 1'h0, s_axi_bready = 1'h0;
  logic s_axi_arvalid = 1'h0, s_axi_rready = 1'h0;
  logic s_axi_awready, s_axi_wready, s_axi_bvalid;
  logic s_axi_arready, s_axi_rvalid;
  logic [1:0] s_axi_bresp, s_axi_rresp, resp;
  logic [31:0] s_axi_rdata, rv;
  int bad_count = 0;
  int compares = 0;
  int cycles = 0;

  always #2 aclk = ~aclk;

  twu_top #(.ADDR_W(8), .NCH(2)) dut_u (
    .aclk(aclk), .aresetn(aresetn), .timer_tick(timer_tick),
    .port_out_value(port_out_value),
    .pin_direction_bit(pin_direction_bit),
    .pin_out(pin_out), .pin_oe(pin_oe),
    .s_axi_awaddr(s_axi_awaddr), .s_axi_awvalid(s_axi_awvalid),
    .s_axi_awready(s_axi_awready), .s_axi_wdata(s_axi_wdata),
    .s_axi_wstrb(s_axi_wstrb), .s_axi_wvalid(s_axi_wvalid),
    .s_axi_wready(s_axi_wready), .s_axi_bresp(s_axi_bresp),
    .s_axi_bvalid(s_axi_bvalid), .s_axi_bready(s_axi_bready),
    .s_axi_araddr(s_axi_araddr), .s_axi_arvalid(s_axi_arvalid),
    .s_axi_arready(s_axi_arready), .s_axi_rdata(s_axi_rdata),
    .s_axi_rresp(s_axi_rresp), .s_axi_rvalid(s_axi_rvalid),
    .s_axi_rready(s_axi_rready)
  );

  twu_pin_load #(.NCH(2)) load_u (
    .aclk(aclk), .pin_out(pin_out), .pin_oe(pin_oe),
    .pin_level(pin_level)
  );

  // ----------------------------------------------------------------
  // tasks
  // ----------------------------------------------------------------
  task report_and_stop;
    $display("compares %0d mismatches %0d", compares, bad_count);
    if (bad_count == 0 && compares > 0) begin
      $display("Testbench passed");
    end else begin
      $display("Testbench failed");
    end
    $finish;
  endtask

  task chk(input logic [31:0] got, input logic [31:0] exp);
    compares++;
    if (got !== exp) begin
      bad_count++;
      $display("ERROR at %0t: got %h expected %h", $time, got, exp);
    end
  endtask

  // each bus, tick and pin task starts on a fresh edge so no strobe is set twice at once
  task wr(input logic [7:0] a, input logic [31:0] d);
    @(posedge aclk);
    s_axi_awaddr <= a;
    s_axi_wdata <= d;
    s_axi_awvalid <= 1'h1;
    s_axi_wvalid <= 1'h1;
    s_axi_bready <= 1'h1;
    do begin
      @(posedge aclk);
      if (s_axi_awvalid && s_axi_awready) s_axi_awvalid <= 1'h0;
      if (s_axi_wvalid && s_axi_wready) s_axi_wvalid <= 1'h0;
    end while (s_axi_bvalid !== 1'h1);
    resp = s_axi_bresp;
    s_axi_bready <= 1'h0;
  endtask

  task rd(input logic [7:0] a);
    @(posedge aclk);
    s_axi_araddr <= a;
    s_axi_arvalid <= 1'h1;
    s_axi_rready <= 1'h1;
    do begin
      @(posedge aclk);
      if (s_axi_arvalid && s_axi_arready) s_axi_arvalid <= 1'h0;
    end while (s_axi_rvalid !== 1'h1);
    rv = s_axi_rdata;
    resp = s_axi_rresp;
    s_axi_rready <= 1'h0;
  endtask

  task rd_chk(input logic [7:0] a, input logic [31:0] exp);
    rd(a);
    chk(rv, exp);
  endtask

  task ticks(input int n);
    repeat (n) begin
      @(posedge aclk);
      timer_tick <= 1'h1;
      @(posedge aclk);
      timer_tick <= 1'h0;
    end
  endtask

  task pins(input logic [1:0] dir, input logic [1:0] val);
    @(posedge aclk);
    pin_direction_bit <= dir;
    port_out_value <= val;
    repeat (3) @(posedge aclk);
  endtask

  function automatic logic [31:0] ctrl(input twu_com_t b, input twu_com_t a,
                                       input logic [2:0] w);
    ctrl = {24'h0, b, a, 1'h0, w};
  endfunction

  always @(posedge aclk) begin
    cycles <= cycles + 1;
    if (cycles == LIMIT) begin
      bad_count++;
      report_and_stop;
    end
  end

  // ----------------------------------------------------------------
  // sequence
  // ----------------------------------------------------------------
  initial begin
    repeat (12) @(posedge aclk);
    aresetn <= 1'h1;
    rd_chk(`TWU_OFF_CTRL, 32'h0);
    rd_chk(`TWU_OFF_OUTST, 32'h0);
    rd(8'h1C);
    chk(resp, `TWU_RESP_SLVERR);
    wr(8'h1C, 32'h0);
    chk(resp, `TWU_RESP_SLVERR);
    s_axi_wstrb <= 4'h0;
    wr(`TWU_OFF_CTRL, 32'hFF);
    s_axi_wstrb <= 4'hF;
    chk(resp, `TWU_RESP_OKAY);
    rd_chk(`TWU_OFF_CTRL, 32'h0);
    chk(resp, `TWU_RESP_OKAY);
    $display("test reset done");
    wr(`TWU_OFF_COUNT, 32'hFE);
    ticks(1);
    rd_chk(`TWU_OFF_COUNT, 32'hFF);
    rd_chk(`TWU_OFF_STATUS, 32'h0);
    ticks(1);
    rd_chk(`TWU_OFF_COUNT, 32'h0);
    rd_chk(`TWU_OFF_STATUS, 32'h1);
    $display("test normal done");
    wr(`TWU_OFF_CTRL, ctrl(COM_OFF, COM_TOGGLE, `TWU_WGM_NORMAL));
    wr(`TWU_OFF_STATUS, 32'h7);
    wr(`TWU_OFF_FORCE, 32'h1);
    rd_chk(`TWU_OFF_OUTST, 32'h1);
    rd_chk(`TWU_OFF_STATUS, 32'h0);
    rd_chk(`TWU_OFF_COUNT, 32'h0);
    pins(2'h1, 2'h2);
    chk(pin_oe, 2'h1);
    chk(pin_level[0], 1'h1);
    pins(2'h3, 2'h2);
    chk(pin_level, 2'h3);
    pins(2'h3, 2'h0);
    chk(pin_level, 2'h1);
    wr(`TWU_OFF_OUTST, 32'h0);
    pins(2'h3, 2'h0);
    chk(pin_level, 2'h0);
    $display("test pins done");
    wr(`TWU_OFF_CMP_A, 32'h3);
    wr(`TWU_OFF_CMP_B, 32'h2);
    wr(`TWU_OFF_COUNT, 32'h0);
    wr(`TWU_OFF_CTRL, ctrl(COM_OFF, COM_TOGGLE, `TWU_WGM_CLR));
    wr(`TWU_OFF_STATUS, 32'h7);
    ticks(4);
    rd_chk(`TWU_OFF_COUNT, 32'h0);
    rd_chk(`TWU_OFF_STATUS, 32'h6);
    rd_chk(`TWU_OFF_OUTST, 32'h1);
    ticks(2);
    wr(`TWU_OFF_CMP_A, 32'h1);
    wr(`TWU_OFF_STATUS, 32'h7);
    ticks(254);
    rd_chk(`TWU_OFF_COUNT, 32'h0);
    rd_chk(`TWU_OFF_STATUS, 32'h5);
    $display("test clear on match done");
    wr(`TWU_OFF_CMP_A, 32'h3);
    wr(`TWU_OFF_CTRL, ctrl(COM_OFF, COM_CLEAR, `TWU_WGM_FPWM_CMP));
    wr(`TWU_OFF_CMP_A, 32'h5);
    wr(`TWU_OFF_COUNT, 32'h0);
    wr(`TWU_OFF_STATUS, 32'h7);
    ticks(4);
    rd_chk(`TWU_OFF_COUNT, 32'h0);
    rd(`TWU_OFF_STATUS);
    chk(rv & 32'h1, 32'h1);
    rd_chk(`TWU_OFF_CMP_A, 32'h5);
    ticks(4);
    rd_chk(`TWU_OFF_COUNT, 32'h4);
    $display("test fast pwm top done");
    wr(`TWU_OFF_CTRL, ctrl(COM_CLEAR, COM_SET, `TWU_WGM_FPWM_MAX));
    wr(`TWU_OFF_COUNT, 32'hFE);
    wr(`TWU_OFF_OUTST, 32'h1);
    ticks(2);
    rd_chk(`TWU_OFF_OUTST, 32'h2);
    ticks(3);
    rd_chk(`TWU_OFF_OUTST, 32'h0);
    ticks(3);
    rd_chk(`TWU_OFF_OUTST, 32'h1);
    pins(2'h3, 2'h2);
    chk(pin_level, 2'h1);
    $display("test fast pwm output done");
    wr(`TWU_OFF_CTRL, ctrl(COM_OFF, COM_TOGGLE, `TWU_WGM_FPWM_MAX));
    wr(`TWU_OFF_COUNT, 32'h4);
    ticks(2);
    rd_chk(`TWU_OFF_OUTST, 32'h0);
    wr(`TWU_OFF_COUNT, 32'h4);
    ticks(2);
    rd_chk(`TWU_OFF_OUTST, 32'h1);
    wr(`TWU_OFF_CMP_A, 32'h0);
    wr(`TWU_OFF_CTRL, ctrl(COM_OFF, COM_CLEAR, `TWU_WGM_FPWM_MAX));
    wr(`TWU_OFF_COUNT, 32'hFF);
    ticks(1);
    rd_chk(`TWU_OFF_OUTST, 32'h1);
    ticks(1);
    rd_chk(`TWU_OFF_OUTST, 32'h0);
    wr(`TWU_OFF_CMP_A, 32'hFF);
    wr(`TWU_OFF_COUNT, 32'hFF);
    ticks(1);
    wr(`TWU_OFF_COUNT, 32'hFE);
    ticks(2);
    rd_chk(`TWU_OFF_OUTST, 32'h1);
    $display("test fast pwm extremes done");
    report_and_stop;
  end
endmodule
